/* verification/anpg_lp_model.sv */
// partner model: cable link partner handing over received pages and events
`timescale 1ns/100ps
`default_nettype none
module anpg_partner_model (
	input  wire logic        clk,
	output logic             base_valid,
	output logic      [15:0] base_word,
	output logic             np_valid,
	output logic      [15:0] np_word,
	output logic             an_able,
	output logic             pd_fault,
	output logic             tx_sent
);
	// ----------------------------------------------------------------
	// page hand-over
	// ----------------------------------------------------------------
	initial begin
		{base_valid, np_valid, an_able, pd_fault, tx_sent} = 5'h00;
		base_word = 16'hA5A5;
		np_word = 16'h5A5A;
	end
	// word held past the sync window, then scrambled so stale data never passes
	task send(input bit np, input logic [15:0] w, input int slow);
		if (np) np_word <= w; else base_word <= w;
		repeat (1 + slow) @(posedge clk);
		if (np) np_valid <= 1'b1; else base_valid <= 1'b1;
		repeat (4) @(posedge clk);
		if (np) np_word <= ~w; else base_word <= ~w;
		if (np) np_valid <= 1'b0; else base_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : send
	task pulse;
		tx_sent <= 1'b1;
		repeat (4) @(posedge clk);
		tx_sent <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task set_flags(input bit a, input bit p);
		an_able <= a;
		pd_fault <= p;
	endtask : set_flags
endmodule : anpg_partner_model
`default_nettype wire

/* verification/anpg_regs_assertions.sv */
// checker: bus and control-pin properties of the page register bank
`timescale 1ns/100ps
`default_nettype none
module anpg_regs_assertions
	import anpg_pkg::*;
(
	input wire logic            CLK,
	input wire logic            RST,
	input wire logic            PSEL,
	input wire logic            PENABLE,
	input wire logic            PWRITE,
	input wire logic [7:0]      PADDR,
	input wire logic [31:0]     PRDATA,
	input wire logic            PREADY,
	input wire logic            PSLVERR,
	input wire logic            TX_NP_SENT,
	input wire logic            STRAP_FULL_DUPLEX,
	input wire logic [15:0]     NP_TX_WORD,
	input wire anpg_test_mode_t TEST_MODE,
	input wire logic            MS_MANUAL,
	input wire logic            MS_MASTER,
	input wire logic            MULTI_PORT,
	input wire logic            ADV_FULL_DUPLEX
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_sent;
		$rose(TX_NP_SENT);
	endsequence
	AST_READY_NEXT: assert property (s_setup |=> PREADY)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	AST_READY_IDLE: assert property (!PSEL |=> !PREADY)
		else $error("ready without select");
	AST_ERR_RANGE: assert property (PREADY && PADDR[7:6] != 2'h0 |-> PSLVERR)
		else $error("out of range access not refused");
	AST_UPPER_ZERO: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_RESET_VALUES: assert property ($fell(RST) |-> MULTI_PORT && !MS_MANUAL &&
		!MS_MASTER && TEST_MODE == TM_NORMAL && NP_TX_WORD == NP_TX_RESET)
		else $error("wrong value after reset");
	AST_MASTER_GATED: assert property (!MS_MANUAL |-> !MS_MASTER)
		else $error("master forced without manual mode");
	AST_TOGGLE_FLIP: assert property (s_sent |-> ##[1:8] $changed(NP_TX_WORD[NP_TOGGLE]))
		else $error("toggle did not flip");
	AST_MODE_HOLD: assert property (!PSEL [*3] |-> $stable(TEST_MODE))
		else $error("test mode moved without a write");
	AST_STRAP_LOAD: assert property ($fell(RST) |-> ##[2:6] ADV_FULL_DUPLEX == STRAP_FULL_DUPLEX)
		else $error("strap not loaded");
endmodule : anpg_regs_assertions
bind anpg_regs anpg_regs_assertions u_chk (.*);
`default_nettype wire

/* verification/test_autoneg_page_and_gigabit_ctrl_regs.sv */
// testbench: page register bank driven over the register bus
`timescale 1ns/100ps
`default_nettype none
module test_autoneg_page_and_gigabit_ctrl_regs;
	import anpg_pkg::*;
	logic            CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
	logic [7:0]      PADDR;
	logic [31:0]     PWDATA, PRDATA;
	logic            LINK_PARTNER_BASE_VALID, LINK_PARTNER_NP_VALID, LINK_PARTNER_AN_ABLE;
	logic            PD_FAULT, TX_NP_SENT;
	logic [15:0]     LINK_PARTNER_BASE_WORD, LINK_PARTNER_NP_WORD, NP_TX_WORD, w, tog;
	logic            STRAP_FULL_DUPLEX, STRAP_HALF_DUPLEX, MS_MANUAL, MS_MASTER;
	logic            MULTI_PORT, ADV_FULL_DUPLEX, ADV_HALF_DUPLEX;
	anpg_test_mode_t TEST_MODE;
	int              err_count, n_tests;
	logic [33:0]     notes[$];
	logic [33:0]     note;
	logic [7:0]      ra[7] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
	logic [31:0]     rv[7] = '{32'h0, 32'h4, 32'h2001, 32'h0, 32'h600, 32'h0, 32'h0};
	anpg_regs dut (.*);
	anpg_partner_model partner (.clk(CLK), .base_valid(LINK_PARTNER_BASE_VALID),
		.base_word(LINK_PARTNER_BASE_WORD), .np_valid(LINK_PARTNER_NP_VALID),
		.np_word(LINK_PARTNER_NP_WORD), .an_able(LINK_PARTNER_AN_ABLE),
		.pd_fault(PD_FAULT), .tx_sent(TX_NP_SENT));
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// ----------------------------------------------------------------
	// checking and bus tasks
	// ----------------------------------------------------------------
	task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	// expectation noted before the request, so the monitor never runs ahead
	task apb(input bit wr, input logic [7:0] a, input logic [31:0] d, input bit e);
		int n;
		notes.push_back({wr, e, d});
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wr ? d : 32'h0;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		// no limit here: a slave that never answers is caught by the watchdog
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1);
		chk("pready wait", n, 32'h1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask : apb
	always @(posedge CLK) begin
		if (PREADY === 1'b1) begin
			if (notes.size() == 0) chk("unexpected ready", 32'h0, 32'h1);
			else begin
				note = notes.pop_front();
				chk("pslverr", {31'h0, PSLVERR}, {31'h0, note[32]});
				if (!note[33] && !note[32]) chk("prdata", PRDATA, note[31:0]);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge CLK);
		err_count++;
		summarize();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h0CFA2318));
		{RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'h8, 40'h0};
		STRAP_FULL_DUPLEX = 1'b1;
		STRAP_HALF_DUPLEX = 1'b0;
		{err_count, n_tests, tog} = '0;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		repeat (8) @(posedge CLK);
		foreach (ra[i]) apb(0, ra[i], rv[i], 0);
		apb(0, 8'h30, 32'h0, 1);
		apb(0, 8'h15, 32'h0, 1);
		apb(1, 8'h54, 32'hFFFF, 1);
		apb(1, 8'h14, 32'hFFFF, 0);
		apb(0, 8'h14, 32'h0, 0);
		apb(1, 8'h2C, 32'h7, 0);
		w = 16'($urandom());
		w[15] = 1'b1;
		partner.send(0, w, 0);
		chk("irq", {31'h0, IRQ}, 32'h1);
		apb(0, 8'h14, {16'h0, w & PARTNER_BASE_MASK}, 0);
		apb(0, 8'h18, 32'hE, 0);
		apb(0, 8'h18, 32'hC, 0);
		apb(0, 8'h28, 32'h1, 0);
		apb(1, 8'h28, 32'h1, 0);
		@(posedge CLK);
		chk("irq", {31'h0, IRQ}, 32'h0);
		apb(1, 8'h2C, 32'h0, 0);
		w = 16'($urandom());
		partner.send(1, w, 3);
		chk("irq", {31'h0, IRQ}, 32'h0);
		apb(0, 8'h20, {16'h0, w}, 0);
		apb(0, 8'h28, 32'h2, 0);
		apb(0, 8'h18, 32'hE, 0);
		partner.set_flags(1, 1);
		repeat (6) @(posedge CLK);
		partner.set_flags(1, 0);
		repeat (6) @(posedge CLK);
		apb(0, 8'h18, 32'h1D, 0);
		apb(0, 8'h18, 32'hD, 0);
		apb(1, 8'h28, 32'h7, 0);
		for (int i = 0; i < 3; i++) begin
			w = 16'($urandom());
			apb(1, 8'h1C, {16'h0, w}, 0);
			apb(0, 8'h1C, {16'h0, (w & NP_TX_WMASK) | tog}, 0);
			chk("np word", {16'h0, NP_TX_WORD}, {16'h0, (w & NP_TX_WMASK) | tog});
			partner.pulse();
			tog ^= 16'h0800;
		end
		// every transmitter test code, undefined ones stored as written
		for (int m = 0; m < 8; m++) begin
			w = 16'($urandom());
			w[15:13] = 3'(m);
			apb(1, 8'h24, {16'h0, w}, 0);
			apb(0, 8'h24, {16'h0, w}, 0);
			chk("mode", {29'h0, TEST_MODE}, {29'h0, w[15:13]});
			chk("ctrl pins", {27'h0, MS_MANUAL, MS_MASTER, MULTI_PORT, ADV_FULL_DUPLEX,
				ADV_HALF_DUPLEX}, {27'h0, w[12], w[12] & w[11], w[10:8]});
		end
		summarize();
	end
endmodule : test_autoneg_page_and_gigabit_ctrl_regs
`default_nettype wire

/* verilog/anpg_page_capture.sv */
// page capture: loads a received page word as a whole on its strobe
`timescale 1ns/100ps
`default_nettype none
module anpg_page_capture (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [15:0] data,
	input  wire logic [15:0] keep_mask,
	output logic      [15:0] q
);
	import anpg_pkg::*;
	logic [15:0] word_r;
	logic [15:0] word_nxt;

	// whole word in one edge, never a partial page
	always_comb begin
		word_nxt = word_r;
		if (load) begin
			word_nxt = data & keep_mask;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			word_r <= 16'h0000;
		end else begin
			word_r <= word_nxt;
		end
	end

	assign q = word_r;
endmodule : anpg_page_capture
`default_nettype wire

/* verilog/anpg_pkg.sv */
// package: offsets, field positions, reset values for the negotiation page registers
package anpg_pkg;
	// ---------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ---------------------------------------------------------------
	localparam logic [3:0]  IDX_PARTNER_BASE = 4'h5;
	localparam logic [3:0]  IDX_EXPANSION = 4'h6;
	localparam logic [3:0]  IDX_NP_TX     = 4'h7;
	localparam logic [3:0]  IDX_PARTNER_NP = 4'h8;
	localparam logic [3:0]  IDX_GIG_CTRL  = 4'h9;
	localparam logic [3:0]  IDX_IRQ_STAT  = 4'hA;
	localparam logic [3:0]  IDX_IRQ_MASK  = 4'hB;
	localparam int          ADDR_LSB      = 2;
	localparam int          ADDR_MSB      = 5;
	// ---------------------------------------------------------------
	// expansion register fields
	// ---------------------------------------------------------------
	localparam int          EXP_PD_FAULT  = 4;
	localparam int          EXP_PARTNER_NP = 3;
	localparam int          EXP_LOC_NP    = 2;
	localparam int          EXP_PAGE_RX   = 1;
	localparam int          EXP_PARTNER_AN = 0;
	// ---------------------------------------------------------------
	// next page word fields
	// ---------------------------------------------------------------
	localparam int          NP_TOGGLE     = 11;
	localparam logic [15:0] NP_TX_WMASK   = 16'hB7FF;
	localparam logic [15:0] NP_TX_RESET   = 16'h2001;
	localparam logic [15:0] PARTNER_BASE_MASK = 16'hEFFF;
	// ---------------------------------------------------------------
	// gigabit control fields
	// ---------------------------------------------------------------
	localparam int          GC_TM_MSB     = 15;
	localparam int          GC_TM_LSB     = 13;
	localparam int          GC_MANUAL     = 12;
	localparam int          GC_MASTER     = 11;
	localparam int          GC_PORT_TYPE  = 10;
	localparam int          GC_FULL_DUP   = 9;
	localparam int          GC_HALF_DUP   = 8;
	localparam logic [15:0] GC_RESET      = 16'h0400;
	// edges after reset release before the synced straps are valid
	localparam logic [1:0]  STRAP_WAIT    = 2'h2;
	// ---------------------------------------------------------------
	// interrupt status bits
	// ---------------------------------------------------------------
	localparam int          IRQ_BASE      = 0;
	localparam int          IRQ_NP        = 1;
	localparam int          IRQ_PD_FAULT  = 2;
	localparam int          IRQ_W         = 3;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
	// ---------------------------------------------------------------
	// transmitter test mode codes
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		TM_NORMAL   = 3'b000,
		TM_WAVEFORM = 3'b001,
		TM_JIT_MAST = 3'b010,
		TM_JIT_SLV  = 3'b011,
		TM_DISTORT  = 3'b100
	} anpg_test_mode_t;
endpackage : anpg_pkg

/* verilog/anpg_regs.sv */
// top: negotiation page and gigabit control register bank behind APB
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - partner base page shown read-only, reset zero
// - parallel detection fault latches high until read
// - page received flag, latching, cleared on read
// - partner next-page and negotiation capability bits
// - local next-page capable reads one; reserved zero
// - writable next page word, code resets one
// - toggle bit inverts previous codeword toggle
// - partner next page shown read-only, reset zero
// - control bits 15:13 pick transmitter test mode
// - manual master/slave forcing via bits 12, 11
// - bit 10 declares multi- or single-port device
// - gigabit duplex abilities reset from strap pins
module anpg_regs (
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire logic                   PSEL,
	input  wire logic                   PENABLE,
	input  wire logic                   PWRITE,
	input  wire logic [7:0]             PADDR,
	input  wire logic [31:0]            PWDATA,
	output logic      [31:0]            PRDATA,
	output logic                        PREADY,
	output logic                        PSLVERR,
	output logic                        IRQ,
	input  wire logic                   LINK_PARTNER_BASE_VALID,
	input  wire logic [15:0]            LINK_PARTNER_BASE_WORD,
	input  wire logic                   LINK_PARTNER_NP_VALID,
	input  wire logic [15:0]            LINK_PARTNER_NP_WORD,
	input  wire logic                   LINK_PARTNER_AN_ABLE,
	input  wire logic                   PD_FAULT,
	input  wire logic                   TX_NP_SENT,
	input  wire logic                   STRAP_FULL_DUPLEX,
	input  wire logic                   STRAP_HALF_DUPLEX,
	output logic      [15:0]            NP_TX_WORD,
	output anpg_pkg::anpg_test_mode_t   TEST_MODE,
	output logic                        MS_MANUAL,
	output logic                        MS_MASTER,
	output logic                        MULTI_PORT,
	output logic                        ADV_FULL_DUPLEX,
	output logic                        ADV_HALF_DUPLEX
);
	import anpg_pkg::*;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [39:0] sync1_r;
	logic [39:0] sync2_r;
	logic [39:0] sync_nxt;

	always_comb begin
		sync_nxt = {LINK_PARTNER_BASE_VALID, LINK_PARTNER_NP_VALID, LINK_PARTNER_AN_ABLE,
			PD_FAULT, TX_NP_SENT, STRAP_FULL_DUPLEX, STRAP_HALF_DUPLEX, 1'b0,
			LINK_PARTNER_BASE_WORD, LINK_PARTNER_NP_WORD};
	end

	// words are qualified by the synced valid edge, so they settle first
	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1_r <= 40'h00_0000_0000;
			sync2_r <= 40'h00_0000_0000;
		end else begin
			sync1_r <= sync_nxt;
			sync2_r <= sync1_r;
		end
	end

	logic        base_v_s;
	logic        np_v_s;
	logic        an_able_s;
	logic        pd_s;
	logic        sent_s;
	logic        strap_fd_s;
	logic        strap_hd_s;
	logic [15:0] base_w_s;
	logic [15:0] np_w_s;

	always_comb begin
		base_v_s   = sync2_r[39];
		np_v_s     = sync2_r[38];
		an_able_s  = sync2_r[37];
		pd_s       = sync2_r[36];
		sent_s     = sync2_r[35];
		strap_fd_s = sync2_r[34];
		strap_hd_s = sync2_r[33];
		base_w_s   = sync2_r[31:16];
		np_w_s     = sync2_r[15:0];
	end

	// ---------------------------------------------------------------
	// edge detect of synced strobes
	// ---------------------------------------------------------------
	logic [2:0] prev_r;
	logic [2:0] prev_nxt;
	logic       base_ev;
	logic       np_ev;
	logic       sent_ev;

	always_comb begin
		prev_nxt = {base_v_s, np_v_s, sent_s};
		base_ev  = base_v_s & ~prev_r[2];
		np_ev    = np_v_s & ~prev_r[1];
		sent_ev  = sent_s & ~prev_r[0];
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			prev_r <= 3'h0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	// ---------------------------------------------------------------
	// partner page holding words
	// ---------------------------------------------------------------
	logic [15:0] base_page_q;
	logic [15:0] next_page_q;

	anpg_page_capture u_base (
		.clk       (CLK),
		.rst       (RST),
		.load      (base_ev),
		.data      (base_w_s),
		.keep_mask (PARTNER_BASE_MASK),
		.q         (base_page_q)
	);

	anpg_page_capture u_np (
		.clk       (CLK),
		.rst       (RST),
		.load      (np_ev),
		.data      (np_w_s),
		.keep_mask (16'hFFFF),
		.q         (next_page_q)
	);

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	function automatic logic [3:0] reg_index(input logic [7:0] a);
		reg_index = a[ADDR_MSB:ADDR_LSB];
	endfunction : reg_index

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && (a[7:6] == 2'h0)
			&& (reg_index(a) >= IDX_PARTNER_BASE) && (reg_index(a) <= IDX_IRQ_MASK);
	endfunction : mapped

	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic [3:0] idx;

	// answer one cycle after setup: pready registered in setup cycle
	always_comb begin
		setup  = PSEL & ~PENABLE;
		idx    = reg_index(PADDR);
		wr_acc = PSEL & PENABLE & PREADY & PWRITE & mapped(PADDR);
		rd_acc = PSEL & PENABLE & PREADY & ~PWRITE & mapped(PADDR);
	end

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic [15:0]      np_tx_r;
	logic [15:0]      np_tx_nxt;
	logic [15:0]      gc_r;
	logic [15:0]      gc_nxt;
	logic             pd_latch_r;
	logic             pd_latch_nxt;
	logic             page_rx_r;
	logic             page_rx_nxt;
	logic             np_able_r;
	logic             np_able_nxt;
	logic             toggle_r;
	logic             toggle_nxt;
	logic [1:0]       strap_cnt_r;
	logic [1:0]       strap_cnt_nxt;
	logic [IRQ_W-1:0] ist_r;
	logic [IRQ_W-1:0] ist_nxt;
	logic [IRQ_W-1:0] imask_r;
	logic [IRQ_W-1:0] imask_nxt;
	logic [15:0]      exp_word;

	always_comb begin
		exp_word = 16'h0000;
		exp_word[EXP_PD_FAULT] = pd_latch_r;
		exp_word[EXP_PARTNER_NP] = np_able_r;
		exp_word[EXP_LOC_NP]   = 1'b1;
		exp_word[EXP_PAGE_RX]  = page_rx_r;
		exp_word[EXP_PARTNER_AN] = an_able_s;
	end

	always_comb begin
		np_tx_nxt      = np_tx_r;
		gc_nxt         = gc_r;
		toggle_nxt     = toggle_r;
		strap_cnt_nxt  = strap_cnt_r;
		imask_nxt      = imask_r;
		np_able_nxt    = np_able_r;
		// strap taken once the synchroniser is full; before that it holds reset zeros
		if (strap_cnt_r <= STRAP_WAIT) begin
			strap_cnt_nxt = strap_cnt_r + 2'h1;
		end
		if (strap_cnt_r == STRAP_WAIT) begin
			gc_nxt[GC_FULL_DUP] = strap_fd_s;
			gc_nxt[GC_HALF_DUP] = strap_hd_s;
		end
		if (base_ev) begin
			np_able_nxt = base_w_s[15];
		end
		// next sent codeword carries the opposite toggle
		if (sent_ev) begin
			toggle_nxt = ~np_tx_r[NP_TOGGLE];
		end
		np_tx_nxt[NP_TOGGLE] = toggle_nxt;
		if (wr_acc && idx == IDX_NP_TX) begin
			np_tx_nxt = (PWDATA[15:0] & NP_TX_WMASK) | (np_tx_r & ~NP_TX_WMASK);
			np_tx_nxt[NP_TOGGLE] = toggle_nxt;
		end
		// full field written, including undefined test codes
		if (wr_acc && idx == IDX_GIG_CTRL) begin
			gc_nxt = PWDATA[15:0];
		end
		if (wr_acc && idx == IDX_IRQ_MASK) begin
			imask_nxt = PWDATA[IRQ_W-1:0];
		end
	end

	// latched flags: a new event wins over the clearing read
	always_comb begin
		pd_latch_nxt = pd_latch_r;
		page_rx_nxt  = page_rx_r;
		// clear only what the read returned: a flag set at the setup edge survives
		if (rd_acc && idx == IDX_EXPANSION) begin
			pd_latch_nxt = pd_latch_r & ~PRDATA[EXP_PD_FAULT];
			page_rx_nxt  = page_rx_r & ~PRDATA[EXP_PAGE_RX];
		end
		if (pd_s) begin
			pd_latch_nxt = 1'b1;
		end
		if (base_ev || np_ev) begin
			page_rx_nxt = 1'b1;
		end
		ist_nxt = ist_r;
		if (wr_acc && idx == IDX_IRQ_STAT) begin
			ist_nxt = ist_r & ~PWDATA[IRQ_W-1:0];
		end
		if (base_ev) begin
			ist_nxt[IRQ_BASE] = 1'b1;
		end
		if (np_ev) begin
			ist_nxt[IRQ_NP] = 1'b1;
		end
		if (pd_s) begin
			ist_nxt[IRQ_PD_FAULT] = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			np_tx_r      <= NP_TX_RESET;
			gc_r         <= GC_RESET;
			pd_latch_r   <= 1'b0;
			page_rx_r    <= 1'b0;
			np_able_r    <= 1'b0;
			toggle_r     <= 1'b0;
			strap_cnt_r  <= 2'h0;
			ist_r        <= {IRQ_W{1'b0}};
			imask_r      <= IRQ_MASK_RESET;
		end else begin
			np_tx_r      <= np_tx_nxt;
			gc_r         <= gc_nxt;
			pd_latch_r   <= pd_latch_nxt;
			page_rx_r    <= page_rx_nxt;
			np_able_r    <= np_able_nxt;
			toggle_r     <= toggle_nxt;
			strap_cnt_r  <= strap_cnt_nxt;
			ist_r        <= ist_nxt;
			imask_r      <= imask_nxt;
		end
	end

	// ---------------------------------------------------------------
	// bus answer and outputs
	// ---------------------------------------------------------------
	logic [31:0]     rdata_nxt;
	logic            ready_nxt;
	logic            err_nxt;
	logic            irq_nxt;
	anpg_test_mode_t tm_nxt;

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		ready_nxt = setup;
		err_nxt   = setup & ~mapped(PADDR);
		if (setup && !PWRITE && mapped(PADDR)) begin
			unique case (idx)
				IDX_PARTNER_BASE: rdata_nxt[15:0] = base_page_q;
				IDX_EXPANSION: rdata_nxt[15:0] = exp_word;
				IDX_NP_TX:     rdata_nxt[15:0] = np_tx_r;
				IDX_PARTNER_NP: rdata_nxt[15:0] = next_page_q;
				IDX_GIG_CTRL:  rdata_nxt[15:0] = gc_r;
				IDX_IRQ_STAT:  rdata_nxt[IRQ_W-1:0] = ist_r;
				IDX_IRQ_MASK:  rdata_nxt[IRQ_W-1:0] = imask_r;
				default:       rdata_nxt = 32'h0000_0000;
			endcase
		end
		irq_nxt = |(ist_nxt & imask_nxt);
		tm_nxt  = anpg_test_mode_t'(gc_nxt[GC_TM_MSB:GC_TM_LSB]);
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			PRDATA          <= 32'h0000_0000;
			PREADY          <= 1'b0;
			PSLVERR         <= 1'b0;
			IRQ             <= 1'b0;
			NP_TX_WORD      <= NP_TX_RESET;
			TEST_MODE       <= TM_NORMAL;
			MS_MANUAL       <= 1'b0;
			MS_MASTER       <= 1'b0;
			MULTI_PORT      <= 1'b1;
			ADV_FULL_DUPLEX <= 1'b0;
			ADV_HALF_DUPLEX <= 1'b0;
		end else begin
			PRDATA          <= rdata_nxt;
			PREADY          <= ready_nxt;
			PSLVERR         <= err_nxt;
			IRQ             <= irq_nxt;
			NP_TX_WORD      <= np_tx_nxt;
			TEST_MODE       <= tm_nxt;
			MS_MANUAL       <= gc_nxt[GC_MANUAL];
			MS_MASTER       <= gc_nxt[GC_MANUAL] & gc_nxt[GC_MASTER];
			MULTI_PORT      <= gc_nxt[GC_PORT_TYPE];
			ADV_FULL_DUPLEX <= gc_nxt[GC_FULL_DUP];
			ADV_HALF_DUPLEX <= gc_nxt[GC_HALF_DUP];
		end
	end
endmodule : anpg_regs
`default_nettype wire
